// File: src/dmci_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DMCI_REGS_SVH
`define DMCI_REGS_SVH
`define DMCI_OFF_CTRL 8'h00
`define DMCI_OFF_HTIME 8'h04
`define DMCI_OFF_VTIME 8'h08
`define DMCI_OFF_CURSOR 8'h0c
`define DMCI_OFF_RMW_ADDR 8'h10
`define DMCI_OFF_RMW_DATA 8'h14
`define DMCI_OFF_STATUS 8'h18
`define DMCI_OFF_RD_DATA 8'h1c
`define DMCI_CTRL_MODE 1:0
`define DMCI_CTRL_REFR 2
`define DMCI_CTRL_FLYB 3
`define DMCI_CTRL_ZOOM 7:4
`define DMCI_CTRL_ROWS 11:8
`define DMCI_HT_TOTAL 7:0
`define DMCI_HT_HS_START 15:8
`define DMCI_HT_HS_WIDTH 23:16
`define DMCI_HT_ACTIVE 31:24
`define DMCI_VT_TOTAL 9:0
`define DMCI_VT_ACTIVE 25:16
`define DMCI_CUR_ADDR 17:0
`define DMCI_CUR_SPLIT 31:22
`define DMCI_RST_CTRL 32'h0000_0f04
`define DMCI_RST_HTIME 32'h28_08_30_3f
`define DMCI_RST_VTIME 32'h00f0_010c
`define DMCI_RST_CURSOR 32'h0000_0000
`define DMCI_RMW_CLOCKS 5'h04
`define DMCI_MIN_CLOCKS 5'h02
`endif

// File: src/dmci_pkg.sv
// types of the display memory cycle interface
package dmci_pkg;
  typedef enum logic [4:0] {
    ST_FIRST = 5'b00001,
    ST_SECOND = 5'b00010,
    ST_RDATA = 5'b00100,
    ST_WBACK = 5'b01000,
    ST_PAD = 5'b10000
  } dmci_state_t;
  typedef enum logic [1:0] {
    CY_DISP = 2'h0,
    CY_RMW = 2'h1,
    CY_REFR = 2'h2,
    CY_BLANK = 2'h3
  } dmci_cycle_t;
  typedef enum logic [1:0] {
    MODE_GRAPH = 2'h0,
    MODE_CHAR = 2'h1,
    MODE_MIXED = 2'h2,
    MODE_RSVD = 2'h3
  } dmci_mode_t;
endpackage

// File: src/dmci_core.sv
// display memory cycle interface with axi4-lite register slave
// Functional notes
// - graphics mode: upper pins plus sixteen bus lines give an 18-bit address.
// - character mode: high upper pin is cursor, low upper pin is line counter msb.
// - mixed mode in hsync: high pin says next line graphics, low pin line clear.
// - mixed mode in active display: high pin cursor, low pin blink timing.
// - upper pins change only in first clock, or fourth clock of modify cycle.
// - hsync position and width are programmed in word times of two clocks.
// - with refresh enabled, hsync cycles put an 8-bit refresh count on bus.
// - blanking marks display cycles only; all other cycle types are blanked.
// - modify cycles compete with display; optionally only during flyback.
// - every memory cycle lasts an even number of clocks, at least two.
// - cycle strobe high in the first clock, low in the second, address valid.
// - cycle strobe stays high at least half a clock before falling.
// - address driven in the first clock, bus released at its end.
// - strobe and read accept reveal no cycle type before mid second clock.
// - character mode puts line counter low three bits on top bus lines.
// - read accept goes low only in modify cycles; data sampled at its end.
// - modify cycles take four clocks at zoom one or two, else zoomed length.
// - each zoom step adds two clocks to display cycles, strobe held high.
`include "dmci_regs.svh"
module dmci_core #(
  parameter int ADDR_W = 8,
  parameter int ZOOM_W = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // display memory pins
  input wire logic [15:0] muxed_addr_data_bus_i,
  output logic [15:0] muxed_addr_data_bus_o,
  output logic muxed_addr_data_bus_oe,
  output logic upper_addr_high_pin,
  output logic upper_addr_low_pin,
  output logic cycle_strobe,
  output logic read_data_accept_n,
  output logic blank,
  output logic hsync
);
  if (ADDR_W < 5 || ZOOM_W != 4)
    $error("dmci_core: ADDR_W must be at least 5 and ZOOM_W must be 4");

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  logic aw_have_q, w_have_q, bvalid_q, rvalid_q, awready_q, wready_q, arready_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] ctrl_q, htime_q, vtime_q, cursor_q, rmw_data_q;
  logic [17:0] rmw_addr_q;
  logic [15:0] rd_data_q;
  logic pend_q;
  // write side: address and data may come in either order
  wire aw_hs = awvalid & awready_q;
  wire w_hs = wvalid & wready_q;
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire aw_have_d = aw_hs | (aw_have_q & ~wr_fire);
  wire w_have_d = w_hs | (w_have_q & ~wr_fire);
  wire [7:0] wa = 8'(awaddr_q);
  wire wr_map = (wa[1:0] == 2'h0) && (wa <= `DMCI_OFF_RMW_DATA);
  wire wr_go = wr_fire && (wa == `DMCI_OFF_RMW_DATA);
  // read side
  wire ar_hs = arvalid & arready_q;
  wire rvalid_d = ar_hs | (rvalid_q & ~rready);
  wire [7:0] ra = 8'(araddr);
  logic [31:0] rd_mux;
  logic rd_map;

  // state shown to software, apart from word_q
  logic [7:0] refr_q, word_q;
  logic [9:0] line_q;
  logic [3:0] chrow_q;
  wire [31:0] status_w = {6'h00, line_q, refr_q, chrow_q, 3'h0, pend_q};
  always_comb
  begin
    rd_map = (ra[1:0] == 2'h0);
    unique case (ra)
      `DMCI_OFF_CTRL: rd_mux = ctrl_q;
      `DMCI_OFF_HTIME: rd_mux = htime_q;
      `DMCI_OFF_VTIME: rd_mux = vtime_q;
      `DMCI_OFF_CURSOR: rd_mux = cursor_q;
      `DMCI_OFF_RMW_ADDR: rd_mux = {14'h0000, rmw_addr_q};
      `DMCI_OFF_RMW_DATA: rd_mux = rmw_data_q;
      `DMCI_OFF_STATUS: rd_mux = status_w;
      `DMCI_OFF_RD_DATA: rd_mux = {16'h0000, rd_data_q};
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_map = 1'b0;
      end
    endcase
  end

  // bus handshake flops; ready drops while an item is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= ~aw_have_d;
      wready_q <= ~w_have_d;
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      bvalid_q <= wr_fire | (bvalid_q & ~bready);
      if (aw_hs)
        awaddr_q <= awaddr;
      if (w_hs)
      begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire)
        bresp_q <= wr_map ? 2'h0 : 2'h2; // unmapped or read-only: slverr
      if (ar_hs)
      begin
        rdata_q <= rd_mux;
        rresp_q <= rd_map ? 2'h0 : 2'h2;
      end
    end
  end

  // memory cycle sequencer state
  dmci_pkg::dmci_state_t st_q, st_d;
  dmci_pkg::dmci_cycle_t cyc_q, cyc_d;
  logic [4:0] remain_q, len_d;
  logic [ZOOM_W-1:0] cyc_zoom_q;
  logic cyc_act_q, cyc_fly_q, phase_q;
  logic [17:0] disp_addr_q, sel_addr;
  logic [5:0] blink_q;
  logic [15:0] bus_o_q, bus_o_d;
  logic bus_oe_q, strobe_q, read_data_accept_n_n_q, blank_q, hsync_q, up_hi_q, up_lo_q, up_hi_d, up_lo_d;

  // configuration fields held in registers
  wire [1:0] mode = ctrl_q[`DMCI_CTRL_MODE];
  wire refr_en = ctrl_q[`DMCI_CTRL_REFR];
  wire fly_only = ctrl_q[`DMCI_CTRL_FLYB];
  wire [ZOOM_W-1:0] zoom_m1 = ctrl_q[`DMCI_CTRL_ZOOM];
  wire [3:0] rows_m1 = ctrl_q[`DMCI_CTRL_ROWS];
  // raster position in word times
  wire [7:0] hs_start = htime_q[`DMCI_HT_HS_START];
  wire [8:0] hs_end = {1'b0, hs_start} + {1'b0, htime_q[`DMCI_HT_HS_WIDTH]};
  wire in_hs = (word_q >= hs_start) && ({1'b0, word_q} < hs_end);
  wire in_act = (word_q < htime_q[`DMCI_HT_ACTIVE]) && (line_q < vtime_q[`DMCI_VT_ACTIVE]);
  wire line_end = (word_q == htime_q[`DMCI_HT_TOTAL]);
  wire frame_end = line_end && (line_q == vtime_q[`DMCI_VT_TOTAL]);
  wire [9:0] next_line = frame_end ? 10'h000 : line_q + 10'h001;
  wire row_start_next = (chrow_q == rows_m1) || frame_end;
  wire cyc_end = (remain_q == 5'h00);
  // arbitration: refresh owns hsync, then modify, then display
  wire rmw_ok = pend_q && !(fly_only && in_act);
  wire [4:0] zlen = {zoom_m1, 1'b0} + `DMCI_MIN_CLOCKS;
  wire rmw_long = (zoom_m1 > 4'h1);

  // type, length and pin values of the cycle about to start
  always_comb
  begin
    if (in_hs)
      cyc_d = refr_en ? dmci_pkg::CY_REFR : dmci_pkg::CY_BLANK;
    else if (rmw_ok)
      cyc_d = dmci_pkg::CY_RMW;
    else if (in_act)
      cyc_d = dmci_pkg::CY_DISP;
    else
      cyc_d = dmci_pkg::CY_BLANK;
    unique case (cyc_d)
      dmci_pkg::CY_DISP: len_d = zlen;
      dmci_pkg::CY_RMW: len_d = rmw_long ? zlen : `DMCI_RMW_CLOCKS;
      default: len_d = `DMCI_MIN_CLOCKS;
    endcase
    sel_addr = (cyc_d == dmci_pkg::CY_RMW) ? rmw_addr_q : disp_addr_q;
    if (cyc_d == dmci_pkg::CY_REFR)
      bus_o_d = {8'h00, refr_q};
    else if (mode == dmci_pkg::MODE_CHAR)
      bus_o_d = {chrow_q[2:0], sel_addr[12:0]};
    else
      bus_o_d = sel_addr[15:0];
    unique case (mode)
      dmci_pkg::MODE_CHAR:
      begin
        up_hi_d = (sel_addr == cursor_q[`DMCI_CUR_ADDR]);
        up_lo_d = chrow_q[3];
      end
      dmci_pkg::MODE_MIXED:
      begin
        up_hi_d = in_hs ? (next_line < cursor_q[`DMCI_CUR_SPLIT])
                        : (sel_addr == cursor_q[`DMCI_CUR_ADDR]);
        up_lo_d = in_hs ? row_start_next : blink_q[5];
      end
      default:
      begin
        up_hi_d = sel_addr[17];
        up_lo_d = sel_addr[16];
      end
    endcase
    priority case (1'b1)
      cyc_end: st_d = dmci_pkg::ST_FIRST;
      st_q[0]: st_d = dmci_pkg::ST_SECOND;
      st_q[1]: st_d = (cyc_q == dmci_pkg::CY_RMW) ? dmci_pkg::ST_RDATA : dmci_pkg::ST_PAD;
      st_q[2]: st_d = dmci_pkg::ST_WBACK;
      default: st_d = dmci_pkg::ST_PAD;
    endcase
  end

  // software registers; a fresh modify request beats the hardware clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `DMCI_RST_CTRL;
      htime_q <= `DMCI_RST_HTIME;
      vtime_q <= `DMCI_RST_VTIME;
      cursor_q <= `DMCI_RST_CURSOR;
      rmw_addr_q <= 18'h00000;
      rmw_data_q <= 32'h0000_0000;
      pend_q <= 1'b0;
    end
    else
    begin
      if (wr_fire && wa == `DMCI_OFF_CTRL)
        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
      if (wr_fire && wa == `DMCI_OFF_HTIME)
        htime_q <= merge(htime_q, wdata_q, wstrb_q);
      if (wr_fire && wa == `DMCI_OFF_VTIME)
        vtime_q <= merge(vtime_q, wdata_q, wstrb_q);
      if (wr_fire && wa == `DMCI_OFF_CURSOR)
        cursor_q <= merge(cursor_q, wdata_q, wstrb_q);
      if (wr_fire && wa == `DMCI_OFF_RMW_ADDR)
        rmw_addr_q <= 18'(merge({14'h0000, rmw_addr_q}, wdata_q, wstrb_q));
      if (wr_go)
        rmw_data_q <= merge(rmw_data_q, wdata_q, wstrb_q);
      pend_q <= wr_go | (pend_q & ~(cyc_end && cyc_d == dmci_pkg::CY_RMW));
    end
  end

  // raster counters; one word time is two clocks, so cycles stay even
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_q <= 1'b0;
      word_q <= 8'h00;
      line_q <= 10'h000;
      chrow_q <= 4'h0;
      blink_q <= 6'h00;
    end
    else
    begin
      phase_q <= ~phase_q;
      if (phase_q)
      begin
        word_q <= line_end ? 8'h00 : word_q + 8'h01;
        if (line_end)
        begin
          line_q <= next_line;
          chrow_q <= row_start_next ? 4'h0 : chrow_q + 4'h1;
          if (frame_end)
            blink_q <= blink_q + 6'h01;
        end
      end
    end
  end

  // memory cycle sequencer and pin flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= dmci_pkg::ST_PAD;
      cyc_q <= dmci_pkg::CY_BLANK;
      remain_q <= 5'h00;
      cyc_zoom_q <= '0;
      cyc_act_q <= 1'b0;
      cyc_fly_q <= 1'b0;
      disp_addr_q <= 18'h00000;
      refr_q <= 8'h00;
      rd_data_q <= 16'h0000;
      bus_o_q <= 16'h0000;
      bus_oe_q <= 1'b0;
      strobe_q <= 1'b0;
      read_data_accept_n_n_q <= 1'b1;
      blank_q <= 1'b1;
      hsync_q <= 1'b0;
      up_hi_q <= 1'b0;
      up_lo_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      remain_q <= cyc_end ? len_d - 5'h01 : remain_q - 5'h01;
      hsync_q <= in_hs;
      read_data_accept_n_n_q <= ~(st_d == dmci_pkg::ST_RDATA);
      strobe_q <= cyc_end || (st_d == dmci_pkg::ST_PAD && cyc_q == dmci_pkg::CY_DISP);
      if (cyc_end)
      begin
        cyc_q <= cyc_d;
        cyc_zoom_q <= zoom_m1;
        cyc_act_q <= in_act;
        cyc_fly_q <= fly_only;
        bus_o_q <= bus_o_d;
        bus_oe_q <= 1'b1;
        blank_q <= (cyc_d != dmci_pkg::CY_DISP);
        up_hi_q <= up_hi_d;
        up_lo_q <= up_lo_d;
        if (cyc_d == dmci_pkg::CY_REFR)
          refr_q <= refr_q + 8'h01;
        if (frame_end)
          disp_addr_q <= 18'h00000;
        else if (cyc_d == dmci_pkg::CY_DISP)
          disp_addr_q <= disp_addr_q + 18'h00001;
      end
      else if (st_q == dmci_pkg::ST_RDATA)
      begin
        // sample at the end of the low read-accept clock, write back next
        rd_data_q <= muxed_addr_data_bus_i;
        bus_o_q <= (muxed_addr_data_bus_i & ~rmw_data_q[31:16])
                 | (rmw_data_q[15:0] & rmw_data_q[31:16]);
        bus_oe_q <= 1'b1;
      end
      else
        bus_oe_q <= 1'b0;
    end
  end

  // ports straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign muxed_addr_data_bus_o = bus_o_q;
  assign muxed_addr_data_bus_oe = bus_oe_q;
  assign upper_addr_high_pin = up_hi_q;
  assign upper_addr_low_pin = up_lo_q;
  assign cycle_strobe = strobe_q;
  assign read_data_accept_n = read_data_accept_n_n_q;
  assign blank = blank_q;
  assign hsync = hsync_q;

  // helper: clocks spent in the cycle in progress
  logic [5:0] cnt_q;
  logic seen_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 6'h00;
      seen_q <= 1'b0;
    end
    else
    begin
      cnt_q <= (st_d == dmci_pkg::ST_FIRST) ? 6'h01 : cnt_q + 6'h01;
      seen_q <= seen_q | (st_q == dmci_pkg::ST_FIRST);
    end
  end

  property p_even_len;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dmci_pkg::ST_FIRST && seen_q) |-> ($past(cnt_q) >= 6'h02 && ($past(cnt_q) % 2) == 0);
  endproperty
  a_even_len: assert property (p_even_len) else $error("cycle length odd or short");
  property p_addr_first;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dmci_pkg::ST_FIRST) |-> (bus_oe_q && strobe_q) ##1 (!bus_oe_q && !strobe_q);
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("address or strobe timing wrong");
  property p_no_early_type;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dmci_pkg::ST_SECOND) |-> (read_data_accept_n && !cycle_strobe);
  endproperty
  a_no_early_type: assert property (p_no_early_type) else $error("cycle type shown early");
  property p_read_data_accept_n_rmw;
    @(posedge aclk) disable iff (!aresetn)
      !read_data_accept_n |-> (cyc_q == dmci_pkg::CY_RMW && st_q == dmci_pkg::ST_RDATA);
  endproperty
  a_read_data_accept_n_rmw: assert property (p_read_data_accept_n_rmw) else $error("read accept outside modify cycle");
  property p_upper_stable;
    @(posedge aclk) disable iff (!aresetn)
      !(st_q inside {dmci_pkg::ST_FIRST, dmci_pkg::ST_WBACK})
        |-> ($stable(upper_addr_high_pin) && $stable(upper_addr_low_pin));
  endproperty
  a_upper_stable: assert property (p_upper_stable) else $error("upper pins moved mid cycle");
  property p_blank_type;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dmci_pkg::ST_FIRST) |-> (blank == (cyc_q != dmci_pkg::CY_DISP));
  endproperty
  a_blank_type: assert property (p_blank_type) else $error("blanking disagrees with cycle");
  property p_refresh_out;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dmci_pkg::ST_FIRST && cyc_q == dmci_pkg::CY_REFR)
        |-> (muxed_addr_data_bus_o[7:0] == refr_q - 8'h01);
  endproperty
  a_refresh_out: assert property (p_refresh_out) else $error("refresh address wrong");
  property p_rmw_four;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dmci_pkg::ST_FIRST && cyc_q == dmci_pkg::CY_RMW && cyc_zoom_q <= 4'h1)
        |-> ##4 (st_q == dmci_pkg::ST_FIRST);
  endproperty
  a_rmw_four: assert property (p_rmw_four) else $error("modify cycle not four clocks");
  property p_zoom_strobe;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dmci_pkg::ST_PAD && cyc_q == dmci_pkg::CY_DISP) |-> cycle_strobe;
  endproperty
  a_zoom_strobe: assert property (p_zoom_strobe) else $error("strobe low in zoom clocks");
  property p_flyback;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dmci_pkg::ST_FIRST && cyc_q == dmci_pkg::CY_RMW && cyc_fly_q) |-> !cyc_act_q;
  endproperty
  a_flyback: assert property (p_flyback) else $error("modify during active display");
endmodule

// File: bench/dmci_mem_model.sv
// display memory partner: stores words and answers modify reads
module dmci_mem_model (
  // clock shared with the device
  input wire logic aclk,
  // device memory pins
  input wire logic cycle_strobe,
  input wire logic oe,
  input wire logic [15:0] bus_o,
  input wire logic up_hi,
  input wire logic up_lo,
  input wire logic read_data_accept_n,
  output logic [15:0] bus_i
);
  logic [15:0] mem [256];
  logic [17:0] cand_q, adr_q, rmw_adr_q;
  logic stb_q, acc_q;
  logic [15:0] last_q;
  // released bus toggles every clock so stale data never looks valid
  assign bus_i = read_data_accept_n ? ~last_q : mem[adr_q[7:0]];
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = {~i[7:0], i[7:0]};
    last_q = 16'h0000;
    stb_q = 1'b0;
    acc_q = 1'b0;
  end
  // cycle start taken from the strobe fall, not its level
  always @(posedge aclk)
  begin
    last_q <= bus_i;
    stb_q <= cycle_strobe;
    acc_q <= !read_data_accept_n;
    if (cycle_strobe && oe)
      cand_q <= {up_hi, up_lo, bus_o};
    if (stb_q && !cycle_strobe)
      adr_q <= cand_q;
    if (!read_data_accept_n)
      rmw_adr_q <= adr_q;
    // only a modify write-back stores; refresh stays row-only
    if (oe && !cycle_strobe && acc_q)
      mem[adr_q[7:0]] <= bus_o;
  end
endmodule

// File: bench/dmci_core_tb_top.sv
// self-checking bench for the display memory cycle interface
`include "dmci_regs.svh"
module dmci_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, oe, up_hi, up_lo;
  logic strobe, acc_n, blank, hsync, c1_q, c1_hp, c1_hs, c1_bl, hs_q, acc_q;
  logic [7:0] awaddr, araddr, rf_last;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, up_q, hs_pins;
  logic [15:0] bus_o, bus_i, c1_bus;
  int num_errors, cmp_count, acc_cnt, zoom_exp, hs_w_exp, len, cur, t1, hs_cnt;
  bit mon_en, flyb_exp, rf_ok, mix_exp;
  dmci_core DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .muxed_addr_data_bus_i(bus_i),
    .muxed_addr_data_bus_o(bus_o), .muxed_addr_data_bus_oe(oe), .upper_addr_high_pin(up_hi),
    .upper_addr_low_pin(up_lo), .cycle_strobe(strobe), .read_data_accept_n(acc_n),
    .blank(blank), .hsync(hsync));
  dmci_mem_model MEM (.aclk(aclk), .cycle_strobe(strobe), .oe(oe), .bus_o(bus_o),
    .up_hi(up_hi), .up_lo(up_lo), .read_data_accept_n(acc_n), .bus_i(bus_i));
  // free-running clock
  initial
  begin
    aclk = 1'b0;
    forever
      #5 aclk = ~aclk;
  end
  // comparison, verdict and hang cut-off
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo();
    num_errors++;
    $display("ERROR wait exp done seen timeout");
    report_and_stop();
  endtask
  // bus master: hold each channel until its ready, then release
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (100)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (!bvalid)
      tmo();
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (100)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (!rvalid)
      tmo();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // monitor is paused across a reconfiguration so half cycles are not judged
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    mon_en <= 1'b0;
    wr(a, d, r);
    repeat (40) @(posedge aclk);
    mon_en <= 1'b1;
  endtask
  function automatic int exp_len(input int t);
    if (t == 0)
      return 2 * (zoom_exp + 1);
    if (t == 1)
      return (zoom_exp <= 1) ? 4 : 2 * (zoom_exp + 1);
    return 2;
  endfunction
  // watch cycle framing, upper pins, hsync width and refresh addresses
  always @(posedge aclk)
  begin
    if (!aresetn || !mon_en)
    begin
      len = 0;
      rf_ok = 0;
      hs_cnt = -1000;
    end
    else
    begin
      if (strobe && oe)
      begin
        if (len != 0)
          chk("cycle_len", len, exp_len(cur));
        if (flyb_exp && cur == 1)
          chk("flyback_rmw", t1 == 0 && !blank, 0);
        t1 = cur;
        cur = blank ? 2 : 0;
        len = 1;
      end
      else if (len != 0)
      begin
        len++;
        if (len == 2)
          chk("strobe_clk2", strobe, 1'b0);
        else if (cur == 0)
          chk("strobe_pad", strobe, 1'b1);
      end
      if (!acc_n && len != 0)
      begin
        acc_cnt++;
        cur = 1;
        chk("accept_clock", len, 3);
        chk("rmw_blank", blank, 1'b1);
      end
      if ({up_hi, up_lo} != up_q)
        chk("upper_change", oe, 1'b1);
      if (oe && !strobe)
        chk("wback_drive", acc_q, 1'b1);
      if (hsync)
        hs_cnt++;
      else if (hs_q)
      begin
        if (hs_cnt > 0)
          chk("hsync_width", hs_cnt, 2 * hs_w_exp);
        hs_cnt = 0;
        // upper pins latched at sync end, as the outside line logic would
        hs_pins = up_q;
        chk("hs_upper_kind", hs_pins[1], mix_exp);
      end
      if (c1_q && c1_hp && c1_hs && hsync)
      begin
        chk("refr_blank", c1_bl, 1'b1);
        chk("refr_high", c1_bus[15:8], 8'h00);
        if (rf_ok)
          chk("refr_step", c1_bus[7:0], 8'(rf_last + 8'h01));
        rf_last = c1_bus[7:0];
        rf_ok = 1;
      end
      if (!hsync)
        rf_ok = 0;
    end
    c1_q = strobe && oe;
    c1_hp = hs_q;
    c1_hs = hsync;
    c1_bus = bus_o;
    c1_bl = blank;
    hs_q = hsync;
    acc_q = !acc_n;
    up_q = {up_hi, up_lo};
  end
  // post one modify and judge memory, pins and read-back
  task automatic do_rmw(input logic [17:0] a, input logic [15:0] d, input logic [15:0] m,
                        input logic [17:0] ma);
    logic [15:0] old;
    logic [31:0] v;
    logic [1:0] r;
    int c;
    old = MEM.mem[a[7:0]];
    c = acc_cnt;
    wr(`DMCI_OFF_RMW_ADDR, {14'h0000, a}, r);
    wr(`DMCI_OFF_RMW_DATA, {m, d}, r);
    v = 32'h0000_0001;
    for (int i = 0; i < 80 && v[0]; i++)
      rd(`DMCI_OFF_STATUS, v, r);
    if (v[0])
      tmo();
    repeat (16) @(posedge aclk); // covers the longest modify cycle run here, six clocks at zoom field 2 (zoom three)
    chk("rmw_word", MEM.mem[a[7:0]], (old & ~m) | (d & m));
    chk("rmw_addr", MEM.rmw_adr_q & ma, a & ma);
    chk("accepts", acc_cnt - c, 1);
    rd(`DMCI_OFF_RD_DATA, v, r);
    chk("rd_data", v, {16'h0000, old});
  endtask
  // reset values, refused accesses and an unmasked register
  task automatic t_regs();
    logic [31:0] v;
    logic [1:0] r;
    logic [7:0] offs [4] = '{`DMCI_OFF_CTRL, `DMCI_OFF_HTIME, `DMCI_OFF_VTIME,
                             `DMCI_OFF_CURSOR};
    logic [31:0] rst [4] = '{`DMCI_RST_CTRL, `DMCI_RST_HTIME, `DMCI_RST_VTIME,
                             `DMCI_RST_CURSOR};
    for (int i = 0; i < 4; i++)
    begin
      rd(offs[i], v, r);
      chk("reset_value", v, rst[i]);
    end
    rd(8'h40, v, r);
    chk("unmapped_rd", {r, v[29:0]}, 32'h8000_0000);
    wr(`DMCI_OFF_STATUS, 32'hffff_ffff, r);
    chk("ro_write", r, 2'h2);
    wr(`DMCI_OFF_CURSOR, 32'hffff_ffff, r);
    rd(`DMCI_OFF_CURSOR, v, r);
    chk("cursor_mask", v, 32'hffff_ffff);
  endtask
  // scenarios: graphics back to back, zoom, flyback-only, character, mixed, hsync
  task automatic t_modes();
    logic [1:0] r;
    do_rmw(18'h2_0005, 16'h1234, 16'h0ff0, 18'h3_ffff);
    do_rmw(18'h2_0005, 16'hff00, 16'hf00f, 18'h3_ffff);
    do_rmw(18'h3_00aa, 16'h5555, 16'hffff, 18'h3_ffff);
    for (int z = 1; z < 3; z++)
    begin
      zoom_exp <= z;
      cfg(`DMCI_OFF_CTRL, 32'h0000_0f04 | (z << 4));
      do_rmw(18'h1_0033, 16'ha5a5, 16'h00ff, 18'h3_ffff);
    end
    zoom_exp <= 0;
    flyb_exp <= 1'b1;
    cfg(`DMCI_OFF_CTRL, 32'h0000_0f0c);
    do_rmw(18'h0_0077, 16'h0f0f, 16'hffff, 18'h3_ffff);
    do_rmw(18'h0_0078, 16'hf0f0, 16'h8001, 18'h3_ffff);
    flyb_exp <= 1'b0;
    cfg(`DMCI_OFF_CTRL, 32'h0000_0f05);
    do_rmw(18'h3_3f12, 16'h3c3c, 16'hffff, 18'h0_1fff);
    // split line above every line, so each sync reports a graphics line
    mix_exp <= 1'b1;
    cfg(`DMCI_OFF_CTRL, 32'h0000_0f06);
    do_rmw(18'h0_1234, 16'h6789, 16'hff00, 18'h0_ffff);
    hs_w_exp <= 3;
    cfg(`DMCI_OFF_HTIME, 32'h2803_303f);
    repeat (400) @(posedge aclk); // about three line periods
  endtask
  // reset, then run every scenario
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, araddr, wdata} = '0;
    {mon_en, flyb_exp, mix_exp, num_errors, cmp_count, acc_cnt, zoom_exp} = '0;
    hs_w_exp = 8;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    mon_en <= 1'b1;
    t_modes();
    report_and_stop();
  end
endmodule
